/* File: dv/prmx_exec_monitor.sv */
// Port checker for the executor.
// Bound onto prmx_exec; one clock, synchronous low reset.
`timescale 1ns/1ps
`include "prmx_cfg.svh"
module prmx_exec_monitor
  import prmx_pkg::*;
(
  input wire logic I_CLK_SYS, // clock
  input wire logic I_RSTN, // reset, low
  input wire logic I_RD, // read strobe
  input wire logic [31:0] O_RDATA, // read data
  input wire logic I_START, // start pulse
  input wire logic [15:0] I_OPCODE, // opcode
  input wire logic [15:0] I_MASK, // mask operand
  input wire logic [31:0] I_IDX_IN, // index-in
  input wire logic [31:0] I_SUBSCRIPT, // subscript
  input wire logic [31:0] I_LOW, // low bound
  input wire logic [31:0] I_HIGH, // high bound
  input wire logic [31:0] I_SIZE, // size
  input wire logic O_READY, // ready
  input wire logic O_DONE, // done pulse
  input wire prmx_fault_t O_FAULT, // fault code
  input wire logic [31:0] O_FAULT_PSL, // pushed status
  input wire logic O_DST_WE, // destination write
  input wire logic [31:0] O_DST_DATA, // destination value
  input wire logic O_HALTED, // halted
  input wire logic O_MEM_RD, // stack read
  input wire logic [31:0] O_MEM_ADDR, // stack address
  input wire logic I_MEM_ACK // stack answer
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RSTN);
  wire go = I_START && O_READY;
  wire [15:0] op = I_OPCODE;
  wire trap = $signed(I_SUBSCRIPT) < $signed(I_LOW) ||
    $signed(I_SUBSCRIPT) > $signed(I_HIGH);
  wire [31:0] idx_exp = (I_IDX_IN + I_SUBSCRIPT) * I_SIZE;
  a_rdata_idle_zero:
    assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not zero outside read slot");
  a_nop_plain_done:
    assert property (go && op == `PRMX_OP_NOP
      |=> O_DONE && O_FAULT == FLT_NONE && !O_DST_WE)
    else $error("no-action opcode misbehaved");
  a_ret_first_pop:
    assert property (go && op == `PRMX_OP_RET |=> !O_DONE && O_MEM_RD)
    else $error("return did not start popping");
  a_mask_rsvd_fault:
    assert property (go && (op == `PRMX_OP_BSET || op == `PRMX_OP_BCLR)
      && I_MASK[15:8] != 8'h00 |=> O_DONE && O_FAULT == FLT_RSVD_OPND)
    else $error("high mask bits did not fault");
  a_bug_rsvd_instr:
    assert property (go && (op == `PRMX_OP_BUGCHECK_WORD_FORM || op == `PRMX_OP_BUGCHECK_LONG_FORM)
      |=> O_DONE && O_FAULT == FLT_RSVD_INSTR)
    else $error("bugcheck opcode did not fault");
  a_bpt_fault_psl:
    assert property (go && op == `PRMX_OP_BPT
      |=> O_FAULT == FLT_BPT && !O_FAULT_PSL[`PRMX_PSL_TP])
    else $error("breakpoint fault wrong");
  a_index_trap:
    assert property (go && op == `PRMX_OP_INDEX
      |=> O_FAULT == ($past(trap) ? FLT_SUBRNG : FLT_NONE))
    else $error("index range trap wrong");
  a_index_value:
    assert property (go && op == `PRMX_OP_INDEX && !trap
      |=> O_DST_WE && O_DST_DATA == $past(idx_exp))
    else $error("index result wrong");
  a_read_status_longword_write:
    assert property (go && op == `PRMX_OP_READ_STATUS_LONGWORD
      |=> O_DONE && O_DST_WE && O_FAULT == FLT_NONE)
    else $error("status longword not written");
  a_mem_req_hold:
    assert property (O_MEM_RD && !I_MEM_ACK
      |=> O_MEM_RD && $stable(O_MEM_ADDR))
    else $error("stack read dropped before answer");
  a_fault_with_done:
    assert property (O_FAULT != FLT_NONE |-> O_DONE)
    else $error("fault code outside done");
  a_halt_blocks:
    assert property (O_HALTED |-> !O_READY)
    else $error("ready while halted");
endmodule // prmx_exec_monitor
bind prmx_exec prmx_exec_monitor u_mon (
  .I_CLK_SYS, .I_RSTN, .I_RD, .O_RDATA, .I_START, .I_OPCODE, .I_MASK,
  .I_IDX_IN, .I_SUBSCRIPT, .I_LOW, .I_HIGH, .I_SIZE, .O_READY, .O_DONE,
  .O_FAULT, .O_FAULT_PSL, .O_DST_WE, .O_DST_DATA, .O_HALTED, .O_MEM_RD,
  .O_MEM_ADDR, .I_MEM_ACK
);

/* File: dv/prmx_stack_mem.sv */
// Behavioural stack memory answering held reads with one ack pulse.
// Bench loads words by hierarchy; slow mode waits extra cycles.
`timescale 1ns/1ps
module prmx_stack_mem (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, low
  input wire logic i_rd, // read request
  input wire logic [31:0] i_addr, // byte address
  input wire logic i_slow, // stretch answers
  output logic [31:0] o_rdata, // read data
  output logic o_ack // answer pulse
);
  logic [31:0] mem [0:255];
  logic [3:0] cnt;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h5A5A_5A5A;
      cnt <= 4'h0;
    end else if (i_rd && !o_ack && cnt >= (i_slow ? 4'h3 : 4'h0)) begin
      o_ack <= 1'b1;
      o_rdata <= mem[i_addr[9:2]];
      cnt <= 4'h0;
    end else begin
      // Data toggles when not answering so a stale value never holds for two cycles running
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt <= i_rd ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // prmx_stack_mem

/* File: dv/test_prmx_exec.sv */
// Self-checking bench of the executor.
// Uses prmx_stack_mem as stack and the bound port checker.
`timescale 1ns/1ps
`include "prmx_cfg.svh"
module test_prmx_exec;
  import prmx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, idx_in = 32'h0, sub = 32'h0, lo = 32'h0;
  logic [31:0] hi = 32'h0, size = 32'h0, npc = 32'h0;
  logic wr = 1'b0, rd = 1'b0, start = 1'b0, slow = 1'b0;
  logic [15:0] opc = 16'h0, mask = 16'h0;
  logic [31:0] rdata, fpsl, ddata, mrdata, maddr, r, d, p;
  logic irq, ready, done, dwe, halted, mrd, mack;
  prmx_fault_t flt, f;
  int fail_count = 0, samples_checked = 0;
  always #2 clk = ~clk;
  prmx_exec u_dut (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_START(start),
    .I_OPCODE(opc), .I_MASK(mask), .I_IDX_IN(idx_in), .I_SUBSCRIPT(sub),
    .I_LOW(lo), .I_HIGH(hi), .I_SIZE(size), .I_NEXT_PC(npc),
    .O_READY(ready), .O_DONE(done), .O_FAULT(flt), .O_FAULT_PSL(fpsl),
    .O_DST_WE(dwe), .O_DST_DATA(ddata), .O_HALTED(halted),
    .O_MEM_RD(mrd), .O_MEM_ADDR(maddr), .I_MEM_RDATA(mrdata),
    .I_MEM_ACK(mack));
  prmx_stack_mem u_mem (.i_clk(clk), .i_rstn(rstn), .i_rd(mrd),
    .i_addr(maddr), .i_slow(slow), .o_rdata(mrdata), .o_ack(mack));
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkf(prmx_fault_t e);
    check("fault", {29'h0, f}, {29'h0, e});
  endtask
  task automatic wr_reg(logic [4:0] a, logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    r = rdata;
  endtask
  task automatic run(logic [15:0] op, logic [15:0] m);
    int n = 0;
    @(posedge clk);
    opc <= op;
    mask <= m;
    npc <= npc + 32'h4;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("done", {31'h0, done}, 32'h1);
    f = flt;
    d = dwe ? ddata : 32'hDEAD_BEEF;
    p = fpsl;
  endtask
  task automatic t_status;
    run(`PRMX_OP_BSET, 16'h000F);
    rd_reg(`PRMX_A_PSL);
    check("psl_set", r, 32'hF);
    run(`PRMX_OP_BCLR, 16'h0005);
    rd_reg(`PRMX_A_PSL);
    check("psl_clr", r, 32'hA);
    for (int i = 0; i < 2; i++) begin
      run(i ? `PRMX_OP_BCLR : `PRMX_OP_BSET, i ? 16'h800A : 16'h0105);
      chkf(FLT_RSVD_OPND);
      rd_reg(`PRMX_A_PSL);
      check("psl_kept", r, 32'hA);
    end
    run(`PRMX_OP_READ_STATUS_LONGWORD, 16'h0);
    check("read_status_longword", d, 32'hA);
    run(`PRMX_OP_NOP, 16'h0);
    rd_reg(5'h0F);
    check("nop_pc", r, npc);
    for (int i = 0; i < 2; i++) begin
      run(i ? `PRMX_OP_BUGCHECK_LONG_FORM : `PRMX_OP_BUGCHECK_WORD_FORM, 16'h0);
      chkf(FLT_RSVD_INSTR);
      rd_reg(`PRMX_A_PSL);
      check("bug_cc", r, 32'hA);
    end
    wr_reg(`PRMX_A_PSL, 32'h4000_0005);
    run(`PRMX_OP_BPT, 16'h0);
    chkf(FLT_BPT);
    check("bpt_psl", p, 32'h5);
    rd_reg(`PRMX_A_PSL);
    check("bpt_cc", {28'h0, r[3:0]}, 32'h0);
  endtask
  task automatic idx_case(logic [31:0] a, b, l, h, z);
    logic [31:0] e;
    logic tr;
    e = (a + b) * z;
    tr = $signed(b) < $signed(l) || $signed(b) > $signed(h);
    wr_reg(`PRMX_A_PSL, 32'h3);
    idx_in <= a;
    sub <= b;
    lo <= l;
    hi <= h;
    size <= z;
    run(`PRMX_OP_INDEX, 16'h0);
    chkf(tr ? FLT_SUBRNG : FLT_NONE);
    if (!tr) begin
      check("idx", d, e);
      rd_reg(`PRMX_A_PSL);
      check("idx_cc", r, {28'h0, e[31], e == 0, 2'b00});
    end
  endtask
  task automatic t_ret;
    wr_reg(5'h0D, 32'h100);
    u_mem.mem[8'h41] = 32'h2801_0009;
    u_mem.mem[8'h42] = 32'h400;
    u_mem.mem[8'h43] = 32'h200;
    u_mem.mem[8'h44] = 32'h300;
    u_mem.mem[8'h45] = 32'h11;
    u_mem.mem[8'h46] = 32'hBB;
    u_mem.mem[8'h47] = 32'h3;
    slow <= 1'b1;
    run(`PRMX_OP_RET, 16'h0);
    slow <= 1'b0;
    chkf(FLT_NONE);
    rd_reg(5'h0E);
    check("sp", r, 32'h12C);
    rd_reg(5'h0F);
    check("pc", r, 32'h400);
    rd_reg(5'h0C);
    check("ap", r, 32'h300);
    rd_reg(5'h00);
    check("r0", r, 32'h11);
    rd_reg(5'h01);
    check("r1", r, 32'h0);
    rd_reg(5'h0B);
    check("r11", r, 32'hBB);
    rd_reg(`PRMX_A_PSL);
    check("ret_psw", r, 32'h9);
    u_mem.mem[8'h81] = 32'hC000_0004;
    u_mem.mem[8'h82] = 32'h500;
    u_mem.mem[8'h83] = 32'h200;
    u_mem.mem[8'h84] = 32'h300;
    run(`PRMX_OP_RET, 16'h0);
    rd_reg(5'h0E);
    check("sp_align", r, 32'h217);
    u_mem.mem[8'h81] = 32'h0000_0104;
    run(`PRMX_OP_RET, 16'h0);
    chkf(FLT_RSVD_OPND);
  endtask
  task automatic t_irq_halt;
    rd_reg(`PRMX_A_IRQ_ST);
    wr_reg(`PRMX_A_IRQ_MSK, 32'h2);
    run(`PRMX_OP_BSET, 16'h0100);
    check("irq_on", {31'h0, irq}, 32'h1);
    rd_reg(`PRMX_A_IRQ_ST);
    check("irq_st", r & 32'h2, 32'h2);
    check("irq_off", {31'h0, irq}, 32'h0);
    rd_reg(5'h14);
    check("unmapped", r, 32'h0);
    wr_reg(`PRMX_A_PSL, 32'h0100_000F);
    run(`PRMX_OP_HALT, 16'h0);
    chkf(FLT_PRIV);
    rd_reg(`PRMX_A_PSL);
    check("priv_cc", {28'h0, r[3:0]}, 32'h0);
    wr_reg(`PRMX_A_PSL, 32'h5);
    run(`PRMX_OP_HALT, 16'h0);
    check("halted", {31'h0, halted}, 32'h1);
    rd_reg(`PRMX_A_PSL);
    check("halt_cc", r, 32'h5);
    wr_reg(`PRMX_A_CTRL, 32'h3);
    @(negedge clk);
    check("resumed", {30'h0, halted, ready}, 32'h1);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`PRMX_A_CTRL);
    check("ctrl_rst", r, 32'h1);
    rd_reg(`PRMX_A_PSL);
    check("psl_rst", r, 32'h0);
    t_status();
    $display("test status done");
    idx_case(32'h0, 32'h3, 32'h1, 32'hF, 32'h19);
    idx_case(32'h2, 32'h5, 32'h5, 32'h5, 32'h0);
    idx_case(32'hFFFF_FFF0, 32'h4, 32'h0, 32'hA, 32'h1);
    idx_case(32'h0, 32'h10, 32'h1, 32'hF, 32'h4);
    idx_case(32'h0, 32'h0, 32'h1, 32'hF, 32'h4);
    $display("test index done");
    t_ret();
    $display("test return done");
    t_irq_halt();
    $display("test irq halt done");
    end_of_test();
  end
endmodule // test_prmx_exec

/* File: include/prmx_cfg.svh */
// Constants of the procedure-return and miscellaneous executor.
// Assumes inclusion by bare name from the include/ folder.
`ifndef PRMX_CFG_SVH
`define PRMX_CFG_SVH
// Opcodes, one-byte forms carry a zero high byte
`define PRMX_OP_HALT 16'h0000
`define PRMX_OP_NOP 16'h0001
`define PRMX_OP_BPT 16'h0003
`define PRMX_OP_RET 16'h0004
`define PRMX_OP_INDEX 16'h000A
`define PRMX_OP_BSET 16'h00B8
`define PRMX_OP_BCLR 16'h00B9
`define PRMX_OP_READ_STATUS_LONGWORD 16'h00DC
`define PRMX_OP_BUGCHECK_LONG_FORM 16'hFDFF
`define PRMX_OP_BUGCHECK_WORD_FORM 16'hFEFF
// Frame control longword fields
`define PRMX_CTL_SPA 31:30
`define PRMX_CTL_ARGS 29
`define PRMX_CTL_MASK 27:16
`define PRMX_CTL_PSW 15:0
`define PRMX_CTL_RSVD 15:8
`define PRMX_MASK_N 4'hC
`define PRMX_LW 32'h0000_0004
// Register numbers
`define PRMX_R_AP 4'hC
`define PRMX_R_FP 4'hD
`define PRMX_R_SP 4'hE
`define PRMX_R_PC 4'hF
// Status longword fields
`define PRMX_PSL_TP 30
`define PRMX_PSL_MODE 25:24
`define PRMX_MODE_KERNEL 2'h0
`define PRMX_PSL_CC 3:0
`define PRMX_PSL_RST 32'h0000_0000
// Register bus word addresses
`define PRMX_A_PSL 5'h10
`define PRMX_A_IRQ_ST 5'h11
`define PRMX_A_IRQ_MSK 5'h12
`define PRMX_A_CTRL 5'h13
`define PRMX_CTRL_EN 0
`define PRMX_CTRL_RESUME 1
`define PRMX_CTRL_RST 2'h1
// Event bits of the interrupt status register
`define PRMX_EV_N 7
`define PRMX_EV_DONE 0
`define PRMX_EV_RSVD_OPND 1
`define PRMX_EV_RSVD_INSTR 2
`define PRMX_EV_PRIV 3
`define PRMX_EV_BPT 4
`define PRMX_EV_SUBRNG 5
`define PRMX_EV_HALT 6
`endif

/* File: include/prmx_pkg.sv */
// Types of the procedure-return and miscellaneous executor.
// Assumes nothing of its surroundings.
package prmx_pkg;
  typedef enum {
    S_IDLE, S_POP_CTL, S_POP_PC, S_POP_FP, S_POP_AP,
    S_SCAN, S_POP_REG, S_ALIGN, S_POP_ARGC, S_FINISH
  } prmx_state_t;
  typedef enum logic [2:0] {
    FLT_NONE, FLT_RSVD_OPND, FLT_RSVD_INSTR, FLT_PRIV, FLT_BPT,
    FLT_SUBRNG
  } prmx_fault_t;
  typedef enum logic [1:0] {ALU_CLR, ALU_SET, ALU_INDEX} prmx_aluop_t;
endpackage

/* File: rtl/prmx_exec.sv */
// Executor for procedure return and miscellaneous instructions.
// Assumes a stack memory that answers a held read with one ack pulse,
// and a master on the register port that keeps the one-cycle protocol.
`timescale 1ns/1ps
`include "prmx_cfg.svh"
module prmx_exec
  import prmx_pkg::*;
#(
  parameter int AW = 5
)
(
  input wire logic I_CLK_SYS, // 250 MHz clock
  input wire logic I_RSTN, // synchronous reset, low
  input wire logic [AW-1:0] I_ADDR, // register word address
  input wire logic [31:0] I_WDATA, // register write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output logic [31:0] O_RDATA, // read data, cycle after strobe
  output logic O_IRQ, // level interrupt
  input wire logic I_START, // instruction start pulse
  input wire logic [15:0] I_OPCODE, // opcode
  input wire logic [15:0] I_MASK, // mask operand
  input wire logic [31:0] I_IDX_IN, // index-in operand
  input wire logic [31:0] I_SUBSCRIPT, // subscript operand
  input wire logic [31:0] I_LOW, // low bound operand
  input wire logic [31:0] I_HIGH, // high bound operand
  input wire logic [31:0] I_SIZE, // size operand
  input wire logic [31:0] I_NEXT_PC, // address after instruction
  output logic O_READY, // start accepted this cycle
  output logic O_DONE, // completion pulse
  output prmx_fault_t O_FAULT, // fault code with done
  output logic [31:0] O_FAULT_PSL, // status longword to push
  output logic O_DST_WE, // destination write pulse
  output logic [31:0] O_DST_DATA, // destination value
  output logic O_HALTED, // processor halted
  output logic O_MEM_RD, // stack read request
  output logic [31:0] O_MEM_ADDR, // stack read address
  input wire logic [31:0] I_MEM_RDATA, // stack read data
  input wire logic I_MEM_ACK // stack read answer
);
  if (AW < 5) begin : g_chk
    $error("AW too small for the register map");
  end

  function automatic logic is_op(input logic [15:0] a,
                                 input logic [15:0] b);
    return a == b;
  endfunction

  logic [31:0] gpr [16];
  logic [31:0] status_longword;
  prmx_state_t state;
  logic [31:0] sp_w;
  logic [31:0] ctl_tmp;
  logic [3:0] idx;
  logic [`PRMX_EV_N-1:0] irq_st;
  logic [`PRMX_EV_N-1:0] irq_msk;
  logic [1:0] ctrl;

  // Decode
  wire go = I_START && O_READY;
  wire op_ret = is_op(I_OPCODE, `PRMX_OP_RET);
  wire op_bclr = is_op(I_OPCODE, `PRMX_OP_BCLR);
  wire op_bset = is_op(I_OPCODE, `PRMX_OP_BSET);
  wire op_bpt = is_op(I_OPCODE, `PRMX_OP_BPT);
  wire op_bug = is_op(I_OPCODE, `PRMX_OP_BUGCHECK_WORD_FORM) ||
                is_op(I_OPCODE, `PRMX_OP_BUGCHECK_LONG_FORM);
  wire op_halt = is_op(I_OPCODE, `PRMX_OP_HALT);
  wire op_index = is_op(I_OPCODE, `PRMX_OP_INDEX);
  wire op_read_status_longword = is_op(I_OPCODE, `PRMX_OP_READ_STATUS_LONGWORD);
  wire op_nop = is_op(I_OPCODE, `PRMX_OP_NOP);
  wire kernel = status_longword[`PRMX_PSL_MODE] == `PRMX_MODE_KERNEL;
  wire pop_ack = O_MEM_RD && I_MEM_ACK;
  wire [31:0] sp_inc = sp_w + `PRMX_LW;
  wire [11:0] rmask = ctl_tmp[`PRMX_CTL_MASK];
  wire [31:0] psl_no_tp = status_longword & ~(32'h1 << `PRMX_PSL_TP);
  wire [31:0] argc_drop = {22'h0, I_MEM_RDATA[7:0], 2'h0};

  prmx_aluop_t alu_op;
  logic [15:0] alu_psw;
  logic alu_rsvd;
  logic [31:0] alu_idx;
  logic alu_trap;
  assign alu_op = op_bset ? ALU_SET : (op_bclr ? ALU_CLR : ALU_INDEX);

  prmx_misc_alu u_alu (
    .i_op(alu_op),
    .i_psw(status_longword[15:0]),
    .i_mask(I_MASK),
    .i_idx_in(I_IDX_IN),
    .i_sub(I_SUBSCRIPT),
    .i_low(I_LOW),
    .i_high(I_HIGH),
    .i_size(I_SIZE),
    .o_psw(alu_psw),
    .o_rsvd(alu_rsvd),
    .o_idx(alu_idx),
    .o_trap(alu_trap)
  );

  // Execution next values
  prmx_state_t next_state;
  logic [31:0] next_sp;
  logic [31:0] next_ctl;
  logic [3:0] next_idx;
  logic x_we;
  logic [3:0] x_reg;
  logic [31:0] x_val;
  logic x_psl_we;
  logic [31:0] x_psl;
  logic x_done;
  prmx_fault_t x_fault;
  logic [31:0] x_fpsl;
  logic x_dst_we;
  logic [31:0] x_dst;
  logic x_halt;

  always_comb begin
    next_state = state;
    next_sp = sp_w;
    next_ctl = ctl_tmp;
    next_idx = idx;
    x_we = 1'b0;
    x_reg = `PRMX_R_PC;
    x_val = I_NEXT_PC;
    x_psl_we = 1'b0;
    x_psl = status_longword;
    x_done = 1'b0;
    x_fault = FLT_NONE;
    x_fpsl = status_longword;
    x_dst_we = 1'b0;
    x_dst = 32'h0;
    x_halt = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (go && op_ret) begin
          next_sp = gpr[`PRMX_R_FP] + `PRMX_LW;
          next_state = S_POP_CTL;
        end else if (go) begin
          x_done = 1'b1;
          x_we = 1'b1;
          if (op_bclr || op_bset) begin
            if (alu_rsvd) begin
              x_we = 1'b0;
              x_fault = FLT_RSVD_OPND;
            end else begin
              x_psl_we = 1'b1;
              x_psl = {status_longword[31:16], alu_psw};
            end
          end else if (op_bpt) begin
            x_we = 1'b0;
            x_fault = FLT_BPT;
            x_fpsl = psl_no_tp;
            x_psl_we = 1'b1;
            x_psl = {psl_no_tp[31:4], 4'h0};
          end else if (op_halt) begin
            if (kernel) begin
              x_halt = 1'b1;
            end else begin
              x_we = 1'b0;
              x_fault = FLT_PRIV;
              x_psl_we = 1'b1;
              x_psl = {status_longword[31:4], 4'h0};
            end
          end else if (op_index) begin
            x_dst_we = 1'b1;
            x_dst = alu_idx;
            x_psl_we = 1'b1;
            x_psl = {status_longword[31:16], alu_psw};
            if (alu_trap) begin
              x_fault = FLT_SUBRNG;
            end
          end else if (op_read_status_longword) begin
            x_dst_we = 1'b1;
            x_dst = status_longword;
          end else if (!op_nop) begin
            x_we = 1'b0;
            x_fault = FLT_RSVD_INSTR;
          end
        end
      end
      S_POP_CTL: begin
        if (pop_ack) begin
          next_ctl = I_MEM_RDATA;
          next_sp = sp_inc;
          next_idx = 4'h0;
          if (|I_MEM_RDATA[`PRMX_CTL_RSVD]) begin
            x_done = 1'b1;
            x_fault = FLT_RSVD_OPND;
            next_state = S_IDLE;
          end else begin
            next_state = S_POP_PC;
          end
        end
      end
      S_POP_PC, S_POP_FP, S_POP_AP: begin
        if (pop_ack) begin
          next_sp = sp_inc;
          x_we = 1'b1;
          x_val = I_MEM_RDATA;
          if (state == S_POP_PC) begin
            x_reg = `PRMX_R_PC;
            next_state = S_POP_FP;
          end else if (state == S_POP_FP) begin
            x_reg = `PRMX_R_FP;
            next_state = S_POP_AP;
          end else begin
            x_reg = `PRMX_R_AP;
            next_state = S_SCAN;
          end
        end
      end
      S_SCAN: begin
        if (idx == `PRMX_MASK_N) begin
          next_state = S_ALIGN;
        end else if (rmask[idx]) begin
          next_state = S_POP_REG;
        end else begin
          next_idx = idx + 4'h1;
        end
      end
      S_POP_REG: begin
        if (pop_ack) begin
          next_sp = sp_inc;
          x_we = 1'b1;
          x_reg = idx;
          x_val = I_MEM_RDATA;
          next_idx = idx + 4'h1;
          next_state = S_SCAN;
        end
      end
      S_ALIGN: begin
        next_sp = sp_w + {30'h0, ctl_tmp[`PRMX_CTL_SPA]};
        next_state = ctl_tmp[`PRMX_CTL_ARGS] ? S_POP_ARGC : S_FINISH;
      end
      S_POP_ARGC: begin
        if (pop_ack) begin
          next_sp = sp_inc + argc_drop;
          next_state = S_FINISH;
        end
      end
      S_FINISH: begin
        x_we = 1'b1;
        x_reg = `PRMX_R_SP;
        x_val = sp_w;
        x_psl_we = 1'b1;
        x_psl = {status_longword[31:16], ctl_tmp[`PRMX_CTL_PSW]};
        x_done = 1'b1;
        next_state = S_IDLE;
      end
    endcase
  end

  // Register port decode
  wire a_gpr = I_ADDR[AW-1:4] == '0;
  wire a_psl = I_ADDR == AW'(`PRMX_A_PSL);
  wire a_st = I_ADDR == AW'(`PRMX_A_IRQ_ST);
  wire a_msk = I_ADDR == AW'(`PRMX_A_IRQ_MSK);
  wire a_ctrl = I_ADDR == AW'(`PRMX_A_CTRL);
  wire idle_bus = state == S_IDLE;
  wire bus_gpr_we = I_WR && a_gpr && idle_bus && !x_we;
  wire bus_psl_we = I_WR && a_psl && idle_bus && !x_psl_we;
  wire rf_we = x_we || bus_gpr_we;
  wire [3:0] rf_reg = x_we ? x_reg : I_ADDR[3:0];
  wire [31:0] rf_val = x_we ? x_val : I_WDATA;
  wire [31:0] rd_mux =
    a_gpr ? gpr[I_ADDR[3:0]] :
    a_psl ? status_longword :
    a_st ? {25'h0, irq_st} :
    a_msk ? {25'h0, irq_msk} :
    a_ctrl ? {31'h0, ctrl[`PRMX_CTRL_EN]} :
    32'h0;

  // Events, set wins over the read clear
  wire [`PRMX_EV_N-1:0] ev;
  assign ev[`PRMX_EV_DONE] = x_done;
  assign ev[`PRMX_EV_RSVD_OPND] = x_fault == FLT_RSVD_OPND;
  assign ev[`PRMX_EV_RSVD_INSTR] = x_fault == FLT_RSVD_INSTR;
  assign ev[`PRMX_EV_PRIV] = x_fault == FLT_PRIV;
  assign ev[`PRMX_EV_BPT] = x_fault == FLT_BPT;
  assign ev[`PRMX_EV_SUBRNG] = x_fault == FLT_SUBRNG;
  assign ev[`PRMX_EV_HALT] = x_halt;
  wire [`PRMX_EV_N-1:0] next_irq_st =
    (irq_st & ~{`PRMX_EV_N{I_RD && a_st}}) | ev;
  wire resume = I_WR && a_ctrl && I_WDATA[`PRMX_CTRL_RESUME];

  assign O_READY = idle_bus && ctrl[`PRMX_CTRL_EN] && !O_HALTED;
  assign O_IRQ = |(irq_st & irq_msk);
  assign O_MEM_RD = (state == S_POP_CTL) || (state == S_POP_PC) ||
                    (state == S_POP_FP) || (state == S_POP_AP) ||
                    (state == S_POP_REG) || (state == S_POP_ARGC);
  assign O_MEM_ADDR = sp_w;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= 32'h0;
      end
    end else if (rf_we) begin
      gpr[rf_reg] <= rf_val;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      state <= S_IDLE;
      sp_w <= 32'h0;
      ctl_tmp <= 32'h0;
      idx <= 4'h0;
    end else begin
      state <= next_state;
      sp_w <= next_sp;
      ctl_tmp <= next_ctl;
      idx <= next_idx;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      status_longword <= `PRMX_PSL_RST;
    end else if (x_psl_we) begin
      status_longword <= x_psl;
    end else if (bus_psl_we) begin
      status_longword <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      irq_st <= '0;
      irq_msk <= '0;
      ctrl <= `PRMX_CTRL_RST;
      O_HALTED <= 1'b0;
      O_RDATA <= 32'h0;
    end else begin
      irq_st <= next_irq_st;
      if (I_WR && a_msk) begin
        irq_msk <= I_WDATA[`PRMX_EV_N-1:0];
      end
      if (I_WR && a_ctrl) begin
        ctrl <= {1'b0, I_WDATA[`PRMX_CTRL_EN]};
      end
      O_HALTED <= x_halt || (O_HALTED && !resume);
      O_RDATA <= I_RD ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_DONE <= 1'b0;
      O_FAULT <= FLT_NONE;
      O_FAULT_PSL <= 32'h0;
      O_DST_WE <= 1'b0;
      O_DST_DATA <= 32'h0;
    end else begin
      O_DONE <= x_done;
      O_FAULT <= x_fault;
      O_FAULT_PSL <= x_fpsl;
      O_DST_WE <= x_dst_we;
      O_DST_DATA <= x_dst;
    end
  end
endmodule // prmx_exec

/* File: rtl/prmx_misc_alu.sv */
// Combinational status-word bit clear/set and compute-index datapath.
// Assumes the caller registers its results.
`timescale 1ns/1ps
`include "prmx_cfg.svh"
module prmx_misc_alu
  import prmx_pkg::*;
(
  input wire prmx_aluop_t i_op, // operation select
  input wire logic [15:0] i_psw, // current status word
  input wire logic [15:0] i_mask, // mask operand
  input wire logic [31:0] i_idx_in, // index-in operand
  input wire logic [31:0] i_sub, // subscript operand
  input wire logic [31:0] i_low, // low bound
  input wire logic [31:0] i_high, // high bound
  input wire logic [31:0] i_size, // element size
  output logic [15:0] o_psw, // new status word
  output logic o_rsvd, // reserved mask bits set
  output logic [31:0] o_idx, // index result
  output logic o_trap // subscript out of range
);
  logic [31:0] sum;
  assign sum = i_idx_in + i_sub;
  assign o_idx = sum * i_size;
  assign o_rsvd = (i_op != ALU_INDEX) && (|i_mask[`PRMX_CTL_RSVD]);
  assign o_trap = (i_op == ALU_INDEX) &&
    (($signed(i_sub) < $signed(i_low)) ||
     ($signed(i_sub) > $signed(i_high)));
  always_comb begin
    unique case (i_op)
      ALU_CLR: o_psw = i_psw & ~i_mask;
      ALU_SET: o_psw = i_psw | i_mask;
      ALU_INDEX: o_psw = {i_psw[15:4], o_idx[31], o_idx == 32'h0,
                          2'h0};
      default: o_psw = i_psw;
    endcase
  end
endmodule // prmx_misc_alu
